// file: inc/sdrcfg_defs.svh
// Register map, field positions, reset values and command pin codes
`ifndef SDRCFG_DEFS_SVH
`define SDRCFG_DEFS_SVH

`define SDRCFG_ADDR_CONFIG 32'hcc000000
`define SDRCFG_ADDR_REFRESH 32'hcc000004
`define SDRCFG_ADDR_CMD 32'hcc000008

`define SDRCFG_BIT_LAT3 3
`define SDRCFG_BIT_DENS64 5
`define SDRCFG_CFG_MASK 32'h0000002f
`define SDRCFG_CFG_RESET 32'h00000000
`define SDRCFG_REFRESH_RESET 16'h0384

// Pin pattern {cs_n, ras_n, cas_n, we_n}
`define SDRCFG_PINS_MRS 4'h0
`define SDRCFG_PINS_PRE 4'h2
`define SDRCFG_PINS_NOP 4'h7
`define SDRCFG_PINS_REF 4'h1
`define SDRCFG_PINS_BST 4'h6
`define SDRCFG_PINS_DESEL 4'hf

// Mode word: single-location writes, standard, sequential, burst of 8
`define SDRCFG_MODE_CL2 13'h0223
`define SDRCFG_MODE_CL3 13'h0233
// Address bit 10 high selects every internal bank
`define SDRCFG_PRE_ALL_ADDR 13'h0400

`endif

// file: inc/sdrcfg_pkg.sv
// Types shared by the configuration, refresh and command logic
package sdrcfg_pkg;

  typedef enum logic [1:0] {
    SDRCFG_ST_IDLE = 2'h0,
    SDRCFG_ST_REFRESH = 2'h1,
    SDRCFG_ST_MANUAL = 2'h2
  } sdrcfg_state_type;

  typedef enum logic [2:0] {
    SDRCFG_CMD_MRS_CL2 = 3'h0,
    SDRCFG_CMD_MRS_CL3 = 3'h1,
    SDRCFG_CMD_PRE_ALL = 3'h2,
    SDRCFG_CMD_NOP = 3'h3,
    SDRCFG_CMD_AUTO_REF = 3'h4,
    SDRCFG_CMD_BURST_STOP = 3'h5,
    SDRCFG_CMD_RSVD6 = 3'h6,
    SDRCFG_CMD_RSVD7 = 3'h7
  } sdrcfg_cmd_type;

endpackage

// file: inc/sdrcfg_refresh_if.sv
// Link between the command sequencer and the refresh timer
`timescale 1ns/1ps
interface sdrcfg_refresh_if;
  logic [15:0] interval;
  logic req;
  logic ack;

  modport ctrl (output interval, output ack, input req);
  modport timer (input interval, input ack, output req);
endinterface

// file: rtl/sdrcfg_refresh_timer.sv
// Automatic refresh interval timer
`timescale 1ns/1ps
module sdrcfg_refresh_timer #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sdrcfg_refresh_if.timer rif
);
  import sdrcfg_pkg::*;

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic req_r;
  logic req_nxt;
  logic hit;

  assign rif.req = req_r;
  assign hit = (count_r + CNT_W'(1)) == rif.interval;

  always_comb begin
    count_nxt = count_r + CNT_W'(1);
    req_nxt = req_r & ~rif.ack;
    if (rif.interval == '0) begin
      count_nxt = '0;
      req_nxt = 1'b0;
    end else if (hit) begin
      count_nxt = '0;
      req_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_r <= '0;
      req_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      req_r <= req_nxt;
    end
  end

  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_zero_disables: assert property (rif.interval == '0 |=> !req_r)
    else $error("refresh request while interval is zero");

  a_timer_restart: assert property ($rose(req_r) |-> count_r == '0)
    else $error("timer did not restart after request");

  a_terminal_count: assert property (
    rif.interval != '0 && hit && $stable(rif.interval) |=> req_r)
    else $error("terminal count did not raise request");
endmodule

// file: rtl/sdrcfg_top.sv
// SDRAM controller configuration, refresh sequencing and manual commands
// Functional notes
// - Config bit 3 selects CAS-to-data latency, 0 two clocks, 1 three.
// - Latency bit resets to 0, giving two-clock latency.
// - Bit 5 set: codes 0-3 decode 64 Mbit arrangements, rest reserved.
// - 16-bit interval sets terminal count; reaching it requests refresh.
// - Interval of zero disables automatic refresh.
// - Automatic refresh invalidates every open page entry.
// - Idle controller starts refresh the clock after the request.
// - Busy controller holds refresh until the transaction completes.
// - Refresh interval resets to 0x0384.
// - Three-bit command register; a write issues that command.
// - Codes 0 and 1 issue mode set with latency 2 or 3, burst 8.
// - Code 2 issues precharge-all to every bank.
// - Code 3 issues a no-operation command.
// - Code 4 auto-refresh, code 5 burst terminate, 6 and 7 reserved.
// - Pins cs,ras,cas,we per command; mode and precharge drive address.
`timescale 1ns/1ps
`include "sdrcfg_defs.svh"
module sdrcfg_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire logic xact_busy,
  output logic cas_lat3,
  output logic [2:0] chip_count,
  output logic [8:0] total_mbyte,
  output logic cfg_reserved,
  output logic page_inval,
  output logic [1:0] sdr_cs_n,
  output logic sdr_ras_n,
  output logic sdr_cas_n,
  output logic sdr_we_n,
  output logic [12:0] sdr_addr
);
  import sdrcfg_pkg::*;
  sdrcfg_refresh_if rif ();

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [15:0] interval_r;
  logic [15:0] interval_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ack_r;
  logic ack_nxt;
  logic cmd_wr;
  sdrcfg_cmd_type cmd_code_r;
  sdrcfg_cmd_type cmd_code_nxt;
  logic cmd_pend_r;
  logic cmd_pend_nxt;
  logic cmd_taken;
  assign cmd_wr = reg_req && reg_wr && reg_addr == `SDRCFG_ADDR_CMD;

  always_comb begin
    cfg_nxt = cfg_r;
    interval_nxt = interval_r;
    rdata_nxt = 32'h00000000;
    ack_nxt = reg_req;
    cmd_code_nxt = cmd_code_r;
    cmd_pend_nxt = cmd_pend_r & ~cmd_taken;
    if (reg_req && reg_wr) begin
      case (reg_addr)
        `SDRCFG_ADDR_CONFIG: cfg_nxt = reg_wdata & `SDRCFG_CFG_MASK;
        `SDRCFG_ADDR_REFRESH: interval_nxt = reg_wdata[15:0];
        `SDRCFG_ADDR_CMD: begin
          // A later write replaces a command still waiting for the bus
          cmd_code_nxt = sdrcfg_cmd_type'(reg_wdata[2:0]);
          cmd_pend_nxt = 1'b1;
        end
        default: cfg_nxt = cfg_r;
      endcase
    end else if (reg_req) begin
      case (reg_addr)
        `SDRCFG_ADDR_CONFIG: rdata_nxt = cfg_r;
        `SDRCFG_ADDR_REFRESH: rdata_nxt = {16'h0000, interval_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_r <= `SDRCFG_CFG_RESET;
      interval_r <= `SDRCFG_REFRESH_RESET;
      rdata_r <= 32'h00000000;
      ack_r <= 1'b0;
      cmd_code_r <= SDRCFG_CMD_NOP;
      cmd_pend_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      interval_r <= interval_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      cmd_code_r <= cmd_code_nxt;
      cmd_pend_r <= cmd_pend_nxt;
    end
  end
  assign rif.interval = interval_r;
  assign reg_rdata = rdata_r;
  assign reg_ack = ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // Memory arrangement decode

  logic [2:0] chips_r;
  logic [2:0] chips_nxt;
  logic [8:0] mbyte_r;
  logic [8:0] mbyte_nxt;
  logic rsvd_r;
  logic rsvd_nxt;
  logic lat3_r;
  always_comb begin
    chips_nxt = 3'h0;
    mbyte_nxt = 9'h000;
    rsvd_nxt = 1'b0;
    if (cfg_r[`SDRCFG_BIT_DENS64]) begin
      case (cfg_r[2:0])
        3'h0: begin chips_nxt = 3'h1; mbyte_nxt = 9'h008; end
        3'h1: begin chips_nxt = 3'h2; mbyte_nxt = 9'h010; end
        3'h2: begin chips_nxt = 3'h2; mbyte_nxt = 9'h010; end
        3'h3: begin chips_nxt = 3'h4; mbyte_nxt = 9'h020; end
        default: rsvd_nxt = 1'b1;
      endcase
    end else begin
      case (cfg_r[2:0])
        3'h0: begin chips_nxt = 3'h2; mbyte_nxt = 9'h020; end
        3'h1: begin chips_nxt = 3'h4; mbyte_nxt = 9'h040; end
        3'h2: begin chips_nxt = 3'h2; mbyte_nxt = 9'h040; end
        3'h3: begin chips_nxt = 3'h4; mbyte_nxt = 9'h080; end
        3'h4: begin chips_nxt = 3'h2; mbyte_nxt = 9'h080; end
        3'h5: begin chips_nxt = 3'h4; mbyte_nxt = 9'h100; end
        default: rsvd_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chips_r <= 3'h0;
      mbyte_r <= 9'h000;
      rsvd_r <= 1'b0;
      lat3_r <= 1'b0;
    end else begin
      chips_r <= chips_nxt;
      mbyte_r <= mbyte_nxt;
      rsvd_r <= rsvd_nxt;
      lat3_r <= cfg_nxt[`SDRCFG_BIT_LAT3];
    end
  end
  assign chip_count = chips_r;
  assign total_mbyte = mbyte_r;
  assign cfg_reserved = rsvd_r;
  assign cas_lat3 = lat3_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  sdrcfg_state_type state_r;
  sdrcfg_state_type state_nxt;
  logic [3:0] pins_r;
  logic [3:0] pins_nxt;
  logic [12:0] addr_r;
  logic [12:0] addr_nxt;
  logic inval_r;
  logic inval_nxt;
  always_comb begin
    state_nxt = state_r;
    pins_nxt = `SDRCFG_PINS_DESEL;
    addr_nxt = 13'h0000;
    inval_nxt = 1'b0;
    rif.ack = 1'b0;
    cmd_taken = 1'b0;
    case (state_r)
      SDRCFG_ST_IDLE: begin
        // Refresh outranks a manual command; both wait out a transaction
        if (rif.req && !xact_busy) begin
          state_nxt = SDRCFG_ST_REFRESH;
          pins_nxt = `SDRCFG_PINS_REF;
          inval_nxt = 1'b1;
          rif.ack = 1'b1;
        end else if (cmd_pend_r && !xact_busy) begin
          state_nxt = SDRCFG_ST_MANUAL;
          cmd_taken = 1'b1;
          case (cmd_code_r)
            SDRCFG_CMD_MRS_CL2: begin
              pins_nxt = `SDRCFG_PINS_MRS;
              addr_nxt = `SDRCFG_MODE_CL2;
            end
            SDRCFG_CMD_MRS_CL3: begin
              pins_nxt = `SDRCFG_PINS_MRS;
              addr_nxt = `SDRCFG_MODE_CL3;
            end
            SDRCFG_CMD_PRE_ALL: begin
              pins_nxt = `SDRCFG_PINS_PRE;
              addr_nxt = `SDRCFG_PRE_ALL_ADDR;
              inval_nxt = 1'b1;
            end
            SDRCFG_CMD_NOP: pins_nxt = `SDRCFG_PINS_NOP;
            SDRCFG_CMD_AUTO_REF: begin
              pins_nxt = `SDRCFG_PINS_REF;
              inval_nxt = 1'b1;
            end
            SDRCFG_CMD_BURST_STOP: pins_nxt = `SDRCFG_PINS_BST;
            // Reserved codes are swallowed as a no-operation
            default: pins_nxt = `SDRCFG_PINS_NOP;
          endcase
        end
      end
      SDRCFG_ST_REFRESH: state_nxt = SDRCFG_ST_IDLE;
      SDRCFG_ST_MANUAL: state_nxt = SDRCFG_ST_IDLE;
      default: state_nxt = SDRCFG_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= SDRCFG_ST_IDLE;
      pins_r <= `SDRCFG_PINS_DESEL;
      addr_r <= 13'h0000;
      inval_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pins_r <= pins_nxt;
      addr_r <= addr_nxt;
      inval_r <= inval_nxt;
    end
  end
  // One chip select pattern drives both banks for these broadcast commands
  assign sdr_cs_n = {2{pins_r[3]}};
  assign sdr_ras_n = pins_r[2];
  assign sdr_cas_n = pins_r[1];
  assign sdr_we_n = pins_r[0];
  assign sdr_addr = addr_r;
  assign page_inval = inval_r;

  sdrcfg_refresh_timer #(.CNT_W(16)) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rif(rif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ref_due;
    rif.req && state_r == SDRCFG_ST_IDLE && !xact_busy;
  endsequence
  sequence s_ref_issued;
    pins_r == `SDRCFG_PINS_REF && inval_r;
  endsequence
  a_latency_select: assert property (lat3_r == cfg_r[`SDRCFG_BIT_LAT3])
    else $error("latency output does not follow config bit");
  a_latency_reset: assert property (
    $rose(rst_n) |-> !lat3_r && interval_r == `SDRCFG_REFRESH_RESET)
    else $error("latency or interval wrong after reset");
  a_refresh_idle: assert property (s_ref_due |=> s_ref_issued)
    else $error("idle refresh not issued next clock");
  a_refresh_hold: assert property (
    rif.req && xact_busy |=> pins_r != `SDRCFG_PINS_REF && rif.req)
    else $error("refresh issued during transaction");
  a_mode_code: assert property (
    pins_r == `SDRCFG_PINS_MRS |->
      addr_r == `SDRCFG_MODE_CL2 || addr_r == `SDRCFG_MODE_CL3)
    else $error("mode set without mode word");
  a_precharge_all: assert property (
    pins_r == `SDRCFG_PINS_PRE |-> addr_r == `SDRCFG_PRE_ALL_ADDR)
    else $error("precharge without all-bank address");
  a_cmd_issue: assert property (
    cmd_wr && reg_wdata[2:0] == 3'h3 && !rif.req && !xact_busy &&
      state_r == SDRCFG_ST_IDLE ##1 !rif.req && !xact_busy && !reg_req
      |=> pins_r == `SDRCFG_PINS_NOP)
    else $error("written nop not issued");
  a_decode_size: assert property (
    !cfg_r[`SDRCFG_BIT_DENS64] && cfg_r[2:0] == 3'h5 |=>
      mbyte_r == 9'h100 && chips_r == 3'h4)
    else $error("arrangement decode wrong");
  a_decode_64: assert property (
    cfg_r[`SDRCFG_BIT_DENS64] && cfg_r[2] |=> rsvd_r)
    else $error("reserved 64 Mbit code not flagged");
endmodule

// file: verification/sdrcfg_sdram_model.sv
// Behavioural model of the SDRAM devices on both chip selects
`timescale 1ns/1ps
module sdrcfg_sdram_model (
  input wire logic ref_clk,
  input wire logic [1:0] sdr_cs_n,
  input wire logic sdr_ras_n,
  input wire logic sdr_cas_n,
  input wire logic sdr_we_n,
  input wire logic [12:0] sdr_addr,
  output logic [12:0] mode_word,
  output int n_ref
);
  initial begin
    mode_word = 13'h0000;
    n_ref = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Devices sample commands on the rising edge after the pins settle
  always @(posedge ref_clk) begin
    if (sdr_cs_n != 2'b11) begin
      if ({sdr_ras_n, sdr_cas_n, sdr_we_n} == 3'h0) begin
        mode_word <= sdr_addr;
      end
      if ({sdr_ras_n, sdr_cas_n, sdr_we_n} == 3'h1) begin
        n_ref <= n_ref + 1;
      end
    end
  end
endmodule

// file: verification/sdrcfg_top_tb.sv
// Self-checking bench for the SDRAM configuration and command block
`timescale 1ns/1ps
`include "sdrcfg_defs.svh"
module sdrcfg_top_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_req = 1'b0;
  logic reg_wr = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic xact_busy = 1'b0;
  logic [31:0] reg_rdata, rd;
  logic reg_ack, cas_lat3, cfg_reserved, page_inval, inval_seen;
  logic sdr_ras_n, sdr_cas_n, sdr_we_n;
  logic [2:0] chip_count;
  logic [8:0] total_mbyte;
  logic [1:0] sdr_cs_n;
  logic [12:0] sdr_addr, mode_word, addr_seen;
  logic [3:0] pins;
  int n_ref, t0;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int chips_t[16] = '{2, 4, 2, 4, 2, 4, 0, 0, 1, 2, 2, 4, 0, 0, 0, 0};
  int mb_t[16] = '{32, 64, 64, 128, 128, 256, 0, 0, 8, 16, 16, 32, 0, 0, 0, 0};
  logic [3:0] pin_t[8] = '{4'h0, 4'h0, 4'h2, 4'h7, 4'h1, 4'h6, 4'h7, 4'h7};
  logic [12:0] addr_t[8] = '{13'h0223, 13'h0233, 13'h0400, 13'h0, 13'h0,
    13'h0, 13'h0, 13'h0};

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  sdrcfg_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .xact_busy(xact_busy),
    .cas_lat3(cas_lat3), .chip_count(chip_count), .total_mbyte(total_mbyte),
    .cfg_reserved(cfg_reserved), .page_inval(page_inval),
    .sdr_cs_n(sdr_cs_n), .sdr_ras_n(sdr_ras_n), .sdr_cas_n(sdr_cas_n),
    .sdr_we_n(sdr_we_n), .sdr_addr(sdr_addr));

  sdrcfg_sdram_model mem (.ref_clk(ref_clk), .sdr_cs_n(sdr_cs_n),
    .sdr_ras_n(sdr_ras_n), .sdr_cas_n(sdr_cas_n), .sdr_we_n(sdr_we_n),
    .sdr_addr(sdr_addr), .mode_word(mode_word), .n_ref(n_ref));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One register access; request held until the edge that takes it
  task automatic access(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge ref_clk) #1;
    reg_req = 1'b1;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_req = 1'b0;
    rd = reg_rdata;
    check("reg_ack", reg_ack, 1'b1);
  endtask

  task automatic wait_cmd(int bound);
    for (int i = 0; i < bound; i++) begin
      @(posedge ref_clk) #1;
      if (sdr_cs_n !== 2'b11) begin
        pins = {sdr_cs_n[0], sdr_ras_n, sdr_cas_n, sdr_we_n};
        addr_seen = sdr_addr;
        inval_seen = page_inval;
        check("cs_pair", sdr_cs_n[1], sdr_cs_n[0]);
        return;
      end
    end
    check("cmd_timeout", 1'b0, 1'b1);
    tally_and_finish();
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("cas_lat3", cas_lat3, 1'b0);
    access(1'b0, `SDRCFG_ADDR_CONFIG, 32'h0);
    check("config", rd, 32'h0);
    access(1'b0, `SDRCFG_ADDR_REFRESH, 32'h0);
    check("refresh", rd, 32'h384);
    access(1'b0, `SDRCFG_ADDR_CMD, 32'h0);
    check("cmd_read", rd, 32'h0);
    access(1'b0, 32'hcc000010, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("Test reset done");
  endtask

  task automatic t_config();
    logic [5:0] v;
    // Latency and arrangement kept consistent with later mode set
    access(1'b1, `SDRCFG_ADDR_CONFIG, 32'hd);
    repeat (2) @(posedge ref_clk);
    #1 check("cas_lat3", cas_lat3, 1'b1);
    check("chips", chip_count, 3'h4);
    check("mbyte", total_mbyte, 9'h100);
    for (int i = 0; i < 16; i++) begin
      v = {i[3], 2'b00, i[2:0]};
      access(1'b1, `SDRCFG_ADDR_CONFIG, 32'hffffffc0 | v);
      access(1'b0, `SDRCFG_ADDR_CONFIG, 32'h0);
      check("cfg_read", rd, v);
      check("cfg_rsv", cfg_reserved, i[3] ? i[2] : i[2:1] == 2'b11);
      if (chips_t[i] != 0) begin
        check("chips", chip_count, chips_t[i]);
        check("mbyte", total_mbyte, mb_t[i]);
      end
    end
    $display("Test config done");
  endtask

  task automatic t_cmds();
    access(1'b1, `SDRCFG_ADDR_REFRESH, 32'h0);
    access(1'b1, `SDRCFG_ADDR_CONFIG, 32'hd);
    for (int c = 0; c < 8; c++) begin
      access(1'b1, `SDRCFG_ADDR_CMD, c);
      wait_cmd(8);
      check("pins", pins, pin_t[c]);
      check("addr", addr_seen, addr_t[c]);
      check("inval", inval_seen, c == 2 || c == 4);
      @(posedge ref_clk) #1;
      check("desel", sdr_cs_n, 2'b11);
    end
    check("mode_word", mode_word, 13'h0233);
    $display("Test commands done");
  endtask

  task automatic t_refresh();
    int r0;
    access(1'b1, `SDRCFG_ADDR_REFRESH, 32'h14);
    wait_cmd(60);
    t0 = cyc;
    check("ref_pins", pins, 4'h1);
    check("ref_inval", inval_seen, 1'b1);
    wait_cmd(60);
    check("period", cyc - t0, 32'h14);
    // Busy spans more than two intervals; only one refresh may wait
    xact_busy = 1'b1;
    repeat (2) @(posedge ref_clk);
    r0 = n_ref;
    repeat (50) @(posedge ref_clk);
    #1 check("held", n_ref, r0);
    xact_busy = 1'b0;
    wait_cmd(2);
    check("late_ref", pins, 4'h1);
    access(1'b1, `SDRCFG_ADDR_REFRESH, 32'h0);
    repeat (2) @(posedge ref_clk);
    r0 = n_ref;
    repeat (100) @(posedge ref_clk);
    #1 check("disabled", n_ref, r0);
    $display("Test refresh done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_config();
    t_cmds();
    t_refresh();
    tally_and_finish();
  end
endmodule
